// ---- shared/tc8_pkg.sv ----
// Purpose: constants and types shared by the 8-bit timer/counter
// Assumes: one clock, plain control ports
// Notes: mode codes follow the 3-bit waveform mode field
package tc8_pkg;
	localparam logic [7:0] TC8_BOTTOM     = 8'h00;
	localparam logic [7:0] TC8_MAX        = 8'hFF;
	localparam logic [7:0] TC8_RST_BYTE   = 8'h00;
	localparam logic [9:0] TC8_PRE_RST    = 10'h000;
	localparam int         TC8_PRE_W      = 10;
	localparam logic [2:0] TC8_CS_STOP    = 3'h0;
	localparam logic [2:0] TC8_CS_CLK     = 3'h1;
	localparam logic [2:0] TC8_CS_DIV8    = 3'h2;
	localparam logic [2:0] TC8_CS_DIV64   = 3'h3;
	localparam logic [2:0] TC8_CS_DIV256  = 3'h4;
	localparam logic [2:0] TC8_CS_DIV1024 = 3'h5;
	localparam logic [2:0] TC8_CS_EXTFALL = 3'h6;
	localparam logic [2:0] TC8_CS_EXTRISE = 3'h7;

	// Waveform modes
	typedef enum logic [2:0] {
		TC8_M_NORMAL   = 3'b000,
		TC8_M_PC_MAX   = 3'b001,
		TC8_M_CLR_MATCH= 3'b010,
		TC8_M_FAST_MAX = 3'b011,
		TC8_M_RSVD4    = 3'b100,
		TC8_M_PC_OCRA  = 3'b101,
		TC8_M_RSVD6    = 3'b110,
		TC8_M_FAST_OCRA= 3'b111
	} tc8_mode_t;

	// Compare output actions
	localparam logic [1:0] TC8_COM_OFF    = 2'h0;
	localparam logic [1:0] TC8_COM_TOGGLE = 2'h1;
	localparam logic [1:0] TC8_COM_CLEAR  = 2'h2;
	localparam logic [1:0] TC8_COM_SET    = 2'h3;
endpackage

// ---- shared/tc8_tick_if.sv ----
// Purpose: tick carrier between clock select and counter
// Assumes: one clock domain
// Notes: tick is a one-cycle enable
`timescale 1ns/100ps
interface tc8_tick_if;
	logic tick;
	modport src (output tick);
	modport dst (input tick);
endinterface // tc8_tick_if

// ---- logic/tc8_clksel.sv ----
// Purpose: free-running prescaler and clock-source select
// Assumes: external count input synchronous to the clock
// Notes: prescaler never resets except on system reset
`timescale 1ns/100ps
module tc8_clksel
	import tc8_pkg::*;
(
	// Clock and reset
	input  wire logic       i_ref_clk,
	input  wire logic       i_rstn,
	// Control
	input  wire logic [2:0] i_clock_source_select,
	input  wire logic       i_external_count_input,
	// Tick out
	tc8_tick_if.src         tick_o
);
	logic [TC8_PRE_W-1:0] pre;
	logic                 ext_q;
	logic                 ext_qq;
	logic                 next_tick;

	wire rise = ext_q & ~ext_qq;
	wire fall = ~ext_q & ext_qq;
	// Tap fires when its low bits reach all ones, the cycle before they wrap
	wire tap8    = &pre[2:0];
	wire tap64   = &pre[5:0];
	wire tap256  = &pre[7:0];
	wire tap1024 = &pre[9:0];

	always_comb begin // R6 R16
		unique case (i_clock_source_select)
			TC8_CS_STOP:    next_tick = 1'b0; // R7
			TC8_CS_CLK:     next_tick = 1'b1;
			TC8_CS_DIV8:    next_tick = tap8;
			TC8_CS_DIV64:   next_tick = tap64;
			TC8_CS_DIV256:  next_tick = tap256;
			TC8_CS_DIV1024: next_tick = tap1024;
			TC8_CS_EXTFALL: next_tick = fall;
			TC8_CS_EXTRISE: next_tick = rise;
		endcase
	end

	always_ff @(posedge i_ref_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			pre    <= TC8_PRE_RST;
			ext_q  <= 1'b0;
			ext_qq <= 1'b0;
		end else begin
			pre    <= pre + 10'h001;
			ext_q  <= i_external_count_input;
			ext_qq <= ext_q;
		end
	end

	assign tick_o.tick = next_tick;
endmodule // tc8_clksel

// ---- logic/tc8_timer.sv ----
// Purpose: 8-bit timer/counter with two compare units and PWM
// Assumes: software writes arrive as one-cycle strobes with data
// Notes: flags clear on interrupt acknowledge or by writing one
// Notes on behaviour
// R1 - Counter and compares are 8-bit registers
// R2 - Two compare units, each flag and pin
// R3 - Compare against counter every cycle
// R4 - Match sets compare flag for interrupt
// R5 - Three sources, one flag, one mask register
// R6 - Tick from prescaler or external pin
// R7 - No clock source keeps counter idle
// R8 - Counter counts up or down by mode
// R9 - Compare registers are double buffered
// R10 - Clear-on-match restarts after compare A
// R11 - Phase correct PWM counts up then down
// R12 - Waveforms on compare pins, ceiling sets period
// R13 - Value 0x00 is the count minimum
// R14 - Value 0xFF is the count maximum
// R15 - Ceiling is 0xFF or compare A
// R16 - Clock select codes 0..7 decoded
// R17 - Counter write beats clear and count
// R18 - Flag set one tick after match
// R19 - Buffer only in PWM modes
// R20 - Reset clears counter, compares, flags, masks
// R21 - Registers accessible with or without tick
`timescale 1ns/100ps
module tc8_timer
	import tc8_pkg::*;
(
	// Clock and reset
	input  wire logic       i_ref_clk,
	input  wire logic       i_rstn,
	// Clock source and mode
	input  wire logic [2:0] i_clock_source_select,
	input  wire logic [2:0] i_wave_mode,
	input  wire logic [1:0] i_com_a,
	input  wire logic [1:0] i_com_b,
	input  wire logic       i_external_count_input,
	// Counter and compare writes
	input  wire logic       i_counter_wr,
	input  wire logic       i_compare_a_wr,
	input  wire logic       i_compare_b_wr,
	input  wire logic [7:0] i_wdata,
	// Flag and mask register
	input  wire logic       i_flag_wr,
	input  wire logic       i_mask_wr,
	input  wire logic [2:0] i_ovf_ack_a_b,
	// Readback
	output logic      [7:0] o_counter_value,
	output logic      [7:0] o_compare_value_a,
	output logic      [7:0] o_compare_value_b,
	output logic      [2:0] o_timer_flag_register,
	output logic      [2:0] o_timer_mask_register,
	// Pins and interrupts
	output logic            o_compare_output_a,
	output logic            o_compare_output_b,
	output logic            o_irq_overflow,
	output logic            o_irq_compare_a,
	output logic            o_irq_compare_b
);
	// Flag and mask bit order: [2]=B, [1]=A, [0]=overflow
	tc8_tick_if tk ();

	logic [7:0] counter_value;
	logic [7:0] compare_value_a;
	logic [7:0] compare_value_b;
	logic [7:0] buf_a;
	logic [7:0] buf_b;
	logic       count_down;
	logic [2:0] flags;
	logic [2:0] masks;
	logic       block_match;
	logic       match_a_q;
	logic       match_b_q;
	logic       out_a;
	logic       out_b;
	logic [7:0] next_counter;
	logic       next_down;

	tc8_clksel u_clksel (
		.i_ref_clk              (i_ref_clk),
		.i_rstn                 (i_rstn),
		.i_clock_source_select  (i_clock_source_select),
		.i_external_count_input (i_external_count_input),
		.tick_o                 (tk.src)
	);

	function automatic logic [1:0] wave_apply(input logic [1:0] com, input logic cur);
		unique case (com)
			TC8_COM_OFF:    wave_apply = {1'b0, cur};
			TC8_COM_TOGGLE: wave_apply = {1'b1, ~cur};
			TC8_COM_CLEAR:  wave_apply = {1'b1, 1'b0};
			TC8_COM_SET:    wave_apply = {1'b1, 1'b1};
		endcase
	endfunction

	wire tick       = tk.tick;
	wire [2:0] mode = i_wave_mode;
	wire is_pc      = (mode == TC8_M_PC_MAX) | (mode == TC8_M_PC_OCRA); // R11
	wire is_fast    = (mode == TC8_M_FAST_MAX) | (mode == TC8_M_FAST_OCRA);
	wire is_pwm     = is_pc | is_fast;
	wire is_clr     = (mode == TC8_M_CLR_MATCH); // R10
	wire top_ocra   = mode[2] | is_clr;
	wire [7:0] top  = top_ocra ? compare_value_a : TC8_MAX; // R15
	wire at_top     = (counter_value == top);
	wire at_bottom  = (counter_value == TC8_BOTTOM); // R13
	wire at_max     = (counter_value == TC8_MAX); // R14
	wire match_a    = (counter_value == compare_value_a); // R3
	wire match_b    = (counter_value == compare_value_b); // R2 R3
	// Update point: top for fast PWM, bottom for phase correct
	wire buf_load   = tick & (is_fast ? at_top : (is_pc & at_bottom)); // R19
	// Overflow: max in normal and clear-on-match, top in fast, bottom in phase correct
	wire ovf_ev     = tick & (is_pc ? at_bottom : (is_clr ? at_max : at_top));
	wire hit_a      = match_a_q & tick & ~block_match; // R18
	wire hit_b      = match_b_q & tick & ~block_match; // R18
	wire [2:0] set_ev = {hit_b, hit_a, ovf_ev};
	wire [2:0] clr_ev = (i_flag_wr ? i_wdata[2:0] : 3'h0) | i_ovf_ack_a_b;
	wire [1:0] wa   = wave_apply(i_com_a, out_a);
	wire [1:0] wb   = wave_apply(i_com_b, out_b);

	always_comb begin // R8
		next_counter = counter_value;
		next_down    = count_down;
		if (tick) begin
			if (is_pc) begin // R11
				if (at_top)
					next_down = 1'b1;
				else if (at_bottom)
					next_down = 1'b0;
				next_counter = (at_top | (count_down & ~at_bottom))
					? counter_value - 8'h01 : counter_value + 8'h01;
			end else if (at_top & (is_clr | is_fast)) begin
				next_counter = TC8_BOTTOM; // R10 R12
				next_down    = 1'b0;
			end else begin
				next_counter = counter_value + 8'h01;
				next_down    = 1'b0;
			end
		end
		if (i_counter_wr)
			next_counter = i_wdata; // R17 R21
	end

	always_ff @(posedge i_ref_clk or negedge i_rstn) begin // R20
		if (!i_rstn) begin
			counter_value <= TC8_RST_BYTE;
			count_down    <= 1'b0;
			block_match   <= 1'b0;
			match_a_q     <= 1'b0;
			match_b_q     <= 1'b0;
		end else begin
			counter_value <= next_counter; // R1
			count_down    <= next_down;
			// Counter write blocks the hit of the following tick, whose latched match the write already cleared
			if (i_counter_wr)
				block_match <= 1'b1;
			else if (tick)
				block_match <= 1'b0;
			if (tick | i_counter_wr) begin
				match_a_q <= match_a & ~i_counter_wr;
				match_b_q <= match_b & ~i_counter_wr;
			end
		end
	end

	always_ff @(posedge i_ref_clk or negedge i_rstn) begin // R9 R19
		if (!i_rstn) begin
			buf_a           <= TC8_RST_BYTE;
			buf_b           <= TC8_RST_BYTE;
			compare_value_a <= TC8_RST_BYTE;
			compare_value_b <= TC8_RST_BYTE;
		end else begin
			if (i_compare_a_wr)
				buf_a <= i_wdata; // R21
			if (i_compare_b_wr)
				buf_b <= i_wdata;
			// Direct write outside PWM avoids a stale buffer
			if (!is_pwm & i_compare_a_wr)
				compare_value_a <= i_wdata;
			else if (buf_load)
				compare_value_a <= buf_a;
			if (!is_pwm & i_compare_b_wr)
				compare_value_b <= i_wdata;
			else if (buf_load)
				compare_value_b <= buf_b;
		end
	end

	always_ff @(posedge i_ref_clk or negedge i_rstn) begin // R4 R5
		if (!i_rstn) begin
			flags <= 3'h0;
			masks <= 3'h0;
		end else begin
			// Set wins over a same-cycle clear
			flags <= (flags & ~clr_ev) | set_ev; // R18
			if (i_mask_wr)
				masks <= i_wdata[2:0];
		end
	end

	always_ff @(posedge i_ref_clk or negedge i_rstn) begin // R12
		if (!i_rstn) begin
			out_a <= 1'b0;
			out_b <= 1'b0;
		end else if (tick) begin
			if (is_pwm) begin
				// Non-inverting on clear code, inverting on set code
				if (i_com_a[1] & match_a)
					out_a <= is_pc ? (i_com_a[0] ^ count_down) : i_com_a[0];
				else if (i_com_a[1] & at_bottom & is_fast)
					out_a <= ~i_com_a[0];
				if (i_com_b[1] & match_b)
					out_b <= is_pc ? (i_com_b[0] ^ count_down) : i_com_b[0];
				else if (i_com_b[1] & at_bottom & is_fast)
					out_b <= ~i_com_b[0];
			end else begin
				if (match_a & wa[1])
					out_a <= wa[0];
				if (match_b & wb[1])
					out_b <= wb[0];
			end
		end
	end

	always_ff @(posedge i_ref_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			o_counter_value       <= TC8_RST_BYTE;
			o_compare_value_a     <= TC8_RST_BYTE;
			o_compare_value_b     <= TC8_RST_BYTE;
			o_timer_flag_register <= 3'h0;
			o_timer_mask_register <= 3'h0;
			o_compare_output_a    <= 1'b0;
			o_compare_output_b    <= 1'b0;
			o_irq_overflow        <= 1'b0;
			o_irq_compare_a       <= 1'b0;
			o_irq_compare_b       <= 1'b0;
		end else begin
			o_counter_value       <= counter_value;
			o_compare_value_a     <= is_pwm ? buf_a : compare_value_a;
			o_compare_value_b     <= is_pwm ? buf_b : compare_value_b;
			o_timer_flag_register <= flags;
			o_timer_mask_register <= masks;
			o_compare_output_a    <= out_a & (i_com_a != TC8_COM_OFF);
			o_compare_output_b    <= out_b & (i_com_b != TC8_COM_OFF);
			o_irq_overflow        <= flags[0] & masks[0]; // R5
			o_irq_compare_a       <= flags[1] & masks[1]; // R4
			o_irq_compare_b       <= flags[2] & masks[2]; // R4
		end
	end
endmodule // tc8_timer

// ---- bench/tc8_timer_asserts.sv ----
// Purpose: port-level checks on the timer/counter
// Assumes: one clock, asynchronous active-low reset
// Notes: three-cycle windows cover an unregistered tick and registered outputs
`timescale 1ns/100ps
module tc8_timer_asserts
	import tc8_pkg::*;
(
	// Clock and reset
	input wire logic       i_ref_clk,
	input wire logic       i_rstn,
	// Watched inputs
	input wire logic [2:0] i_clock_source_select,
	input wire logic [2:0] i_wave_mode,
	input wire logic       i_counter_wr,
	input wire logic       i_compare_a_wr,
	input wire logic       i_mask_wr,
	input wire logic [7:0] i_wdata,
	// Watched outputs
	input wire logic [7:0] o_counter_value,
	input wire logic [7:0] o_compare_value_a,
	input wire logic [2:0] o_timer_flag_register,
	input wire logic [2:0] o_timer_mask_register,
	input wire logic       o_irq_compare_a,
	input wire logic       o_irq_compare_b
);
	default clocking cb @(posedge i_ref_clk); endclocking
	default disable iff (!i_rstn);
	wire       run = i_clock_source_select == TC8_CS_CLK && !i_counter_wr && !i_compare_a_wr;
	wire [2:0] wlo = i_wdata[2:0];
	AST_STOP: assert property ((i_clock_source_select == TC8_CS_STOP && !i_counter_wr)[*3]
		|=> $stable(o_counter_value)) else $error("counter moved while stopped");
	AST_COUNT_UP: assert property ((run && i_wave_mode == TC8_M_NORMAL)[*3]
		|=> o_counter_value == $past(o_counter_value) + 8'h01) else $error("no count");
	AST_CNT_WR: assert property (i_counter_wr |-> ##2 o_counter_value == $past(i_wdata, 2))
		else $error("counter write lost");
	AST_MASK: assert property (i_mask_wr |-> ##2 o_timer_mask_register == $past(wlo, 2))
		else $error("mask write lost");
	AST_CLR_MATCH: assert property ((run && i_wave_mode == TC8_M_CLR_MATCH)[*3]
		##0 o_counter_value == o_compare_value_a |=> o_counter_value == TC8_BOTTOM)
		else $error("no clear at ceiling");
	AST_PC_TOP: assert property ((run && i_wave_mode == TC8_M_PC_MAX)[*3]
		##0 o_counter_value == TC8_MAX |=> o_counter_value == 8'hFE)
		else $error("no turn at max");
	AST_PC_BOT: assert property ((run && i_wave_mode == TC8_M_PC_MAX)[*3]
		##0 o_counter_value == TC8_BOTTOM |=> o_counter_value == 8'h01)
		else $error("no turn at bottom");
	AST_IRQ_A: assert property (o_irq_compare_a == (o_timer_flag_register[1]
		&& o_timer_mask_register[1])) else $error("irq a wrong");
	AST_IRQ_B: assert property (o_irq_compare_b == (o_timer_flag_register[2]
		&& o_timer_mask_register[2])) else $error("irq b wrong");
	cover property (i_counter_wr);
	cover property (o_irq_compare_a);
	cover property (i_wave_mode == TC8_M_CLR_MATCH && o_counter_value == o_compare_value_a);
endmodule // tc8_timer_asserts
bind tc8_timer tc8_timer_asserts u_tc8_timer_asserts (.i_ref_clk(i_ref_clk), .i_rstn(i_rstn),
	.i_clock_source_select(i_clock_source_select), .i_wave_mode(i_wave_mode),
	.i_counter_wr(i_counter_wr), .i_compare_a_wr(i_compare_a_wr), .i_mask_wr(i_mask_wr),
	.i_wdata(i_wdata), .o_counter_value(o_counter_value), .o_compare_value_a(o_compare_value_a),
	.o_timer_flag_register(o_timer_flag_register), .o_timer_mask_register(o_timer_mask_register),
	.o_irq_compare_a(o_irq_compare_a), .o_irq_compare_b(o_irq_compare_b));

// ---- bench/tc8_timer_test.sv ----
// Purpose: directed bench for the timer/counter
// Assumes: outputs lag register state by one cycle
// Notes: tick rates measured over whole periods, so phase is irrelevant
`timescale 1ns/100ps
module tc8_timer_test
	import tc8_pkg::*;
;
	logic       i_ref_clk = 1'b0;
	logic       i_rstn = 1'b0;
	logic [2:0] cs = 3'h0, mode = 3'h0, ack = 3'h0, flg, msk;
	logic [1:0] com_a = 2'h0, com_b = 2'h0;
	logic       ext = 1'b0, pa, pb, iov, ia, ib;
	logic [4:0] wr = 5'h00;
	logic [7:0] wd = 8'h00, cnt, cpa, cpb, v0, mx;
	int         err_count = 0, check_count = 0, n, m;
	int         dv [1:5] = '{1, 8, 64, 256, 1024};

	tc8_timer u_tc8_timer (.i_ref_clk(i_ref_clk), .i_rstn(i_rstn), .i_clock_source_select(cs),
		.i_wave_mode(mode), .i_com_a(com_a), .i_com_b(com_b), .i_external_count_input(ext),
		.i_counter_wr(wr[4]), .i_compare_a_wr(wr[3]), .i_compare_b_wr(wr[2]), .i_wdata(wd),
		.i_flag_wr(wr[1]), .i_mask_wr(wr[0]), .i_ovf_ack_a_b(ack), .o_counter_value(cnt),
		.o_compare_value_a(cpa), .o_compare_value_b(cpb), .o_timer_flag_register(flg),
		.o_timer_mask_register(msk), .o_compare_output_a(pa), .o_compare_output_b(pb),
		.o_irq_overflow(iov), .o_irq_compare_a(ia), .o_irq_compare_b(ib));

	always #5 i_ref_clk = ~i_ref_clk;

	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", check_count, err_count);
		if (err_count == 0 && check_count > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		check_count++;
		if (seen !== exp) begin
			err_count++;
			$display("CHECK FAILED at %0t: saw %h want %h", $time, seen, exp);
		end
	endtask
	task automatic cyc(input int k);
		repeat (k) @(posedge i_ref_clk);
		#1;
	endtask
	// Strobe bits: counter, compare a, compare b, flag, mask
	task automatic put(input logic [4:0] s, input logic [7:0] d);
		@(posedge i_ref_clk);
		wr <= s;
		wd <= d;
		@(posedge i_ref_clk);
		wr <= 5'h00;
		#1;
	endtask
	task automatic sel(input logic [2:0] c);
		@(posedge i_ref_clk);
		cs <= c;
		#1;
	endtask
	task automatic wait_for(input logic [7:0] v, input int lim);
		n = 0;
		while (cnt !== v && n < lim) begin
			cyc(1);
			n++;
		end
		if (cnt !== v) begin
			chk(cnt, v);
			report_and_stop;
		end
	endtask
	task automatic run_flag(input logic [7:0] start);
		put(5'h10, start);
		sel(TC8_CS_CLK);
		cyc(10);
		sel(TC8_CS_STOP);
		cyc(3);
	endtask

	initial begin
		repeat (4) @(posedge i_ref_clk);
		i_rstn <= 1'b1;
		cyc(2);
		chk(cnt | cpa | cpb | {5'h00, flg | msk}, 8'h00);
		put(5'h10, 8'h05);
		put(5'h08, 8'h33);
		put(5'h04, 8'h44);
		cyc(20);
		chk(cnt, 8'h05);
		chk(cpa ^ cpb, 8'h77);
		$display("test reset and stop done");
		for (int i = 1; i < 6; i++) begin
			sel(3'(i));
			cyc(4);
			v0 = cnt;
			cyc(3 * dv[i]);
			chk(cnt, v0 + 8'h03);
		end
		for (int i = 6; i < 8; i++) begin
			sel(3'(i));
			cyc(4);
			v0 = cnt;
			repeat (10) begin
				@(posedge i_ref_clk);
				ext <= ~ext;
				cyc(2);
			end
			cyc(5);
			chk(cnt, v0 + 8'h05);
		end
		sel(TC8_CS_STOP);
		$display("test clock sources done");
		put(5'h01, 8'h02);
		put(5'h08, 8'h20);
		run_flag(8'h1C);
		chk({flg, msk, ia, ib}, 8'h4A);
		put(5'h02, 8'h02);
		cyc(2);
		chk({flg, ia}, 8'h00);
		run_flag(8'h1C);
		chk(flg, 8'h02);
		@(posedge i_ref_clk);
		ack <= 3'h2;
		@(posedge i_ref_clk);
		ack <= 3'h0;
		cyc(2);
		chk(flg, 8'h00);
		put(5'h01, 8'h01);
		run_flag(8'hFA);
		chk({flg, iov}, 8'h03);
		$display("test flags done");
		@(posedge i_ref_clk);
		mode <= TC8_M_CLR_MATCH;
		com_a <= TC8_COM_TOGGLE;
		com_b <= TC8_COM_TOGGLE;
		put(5'h08, 8'h0A);
		put(5'h04, 8'h05);
		put(5'h10, 8'h00);
		sel(TC8_CS_CLK);
		cyc(4);
		mx = 8'h00;
		n = 0;
		m = 0;
		v0[0] = pa;
		v0[1] = pb;
		repeat (44) begin
			cyc(1);
			if (cnt > mx) mx = cnt;
			if (pa !== v0[0]) n++;
			if (pb !== v0[1]) m++;
			v0[0] = pa;
			v0[1] = pb;
		end
		chk(mx, 8'h0A);
		chk(8'(n), 8'h04);
		chk(8'(m), 8'h04);
		$display("test clear on match done");
		@(posedge i_ref_clk);
		mode <= TC8_M_PC_MAX;
		com_a <= TC8_COM_CLEAR;
		com_b <= TC8_COM_OFF;
		put(5'h10, 8'hF0);
		wait_for(8'hFF, 40);
		cyc(1);
		chk(cnt, 8'hFE);
		wait_for(8'h00, 300);
		cyc(1);
		chk(cnt, 8'h01);
		chk({7'h00, pa}, 8'h01);
		wait_for(8'h0C, 20);
		chk({7'h00, pa}, 8'h00);
		$display("test phase correct done");
		sel(TC8_CS_STOP);
		@(posedge i_ref_clk);
		mode <= TC8_M_FAST_MAX;
		put(5'h10, 8'h10);
		put(5'h02, 8'h07);
		put(5'h08, 8'h12);
		sel(TC8_CS_CLK);
		cyc(6);
		chk(flg, 8'h00);
		wait_for(8'h14, 300);
		chk({7'h00, flg[1]}, 8'h01);
		sel(TC8_CS_STOP);
		@(posedge i_ref_clk);
		i_rstn <= 1'b0;
		cyc(2);
		@(posedge i_ref_clk);
		i_rstn <= 1'b1;
		cyc(2);
		chk(cnt | cpa | cpb | {5'h00, flg | msk}, 8'h00);
		$display("test fast pwm and reset done");
		report_and_stop;
	end
endmodule // tc8_timer_test
